// [logic/twst_slave_tx.sv]
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
module twst_slave_tx
  import twst_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  input  wire logic              SCL_IN,
  output logic                   SCL_OUT,
  output logic                   SCL_OE,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  input  wire logic              ARB_LOST,
  output logic                   START_ISSUE,
  output logic                   STEP_DONE
);

  typedef struct packed {
    twst_state_t         state;
    logic                ack_en;
    logic                begin_req;
    logic                halt_req;
    logic                enable;
    logic                flag;
    logic [DATA_W-1:0]   code;
    logic [DATA_W-1:0]   data_byte;
    logic [DATA_W-1:0]   own_addr;
    logic [DATA_W-1:0]   shifter;
    logic [BITCNT_W-1:0] bitcnt;
    logic                last_byte;
    logic                ack_seen;
    logic                scl_prev;
    logic                sda_prev;
    logic                busy;
    logic                start_pending;
    logic                start_issue;
    logic                scl_drive;
    logic                sda_drive;
    logic [DATA_W-1:0]   rdata;
  } twst_regs_t;

  localparam twst_regs_t REGS_RESET = '{
    state:         ST_IDLE,
    ack_en:        1'b0,
    begin_req:     1'b0,
    halt_req:      1'b0,
    enable:        1'b0,
    flag:          1'b0,
    code:          CODE_NO_INFO,
    data_byte:     RST_BYTE,
    own_addr:      RST_BYTE,
    shifter:       RST_BYTE,
    bitcnt:        CNT_ZERO,
    last_byte:     1'b0,
    ack_seen:      1'b0,
    scl_prev:      1'b1,
    sda_prev:      1'b1,
    busy:          1'b0,
    start_pending: 1'b0,
    start_issue:   1'b0,
    scl_drive:     1'b0,
    sda_drive:     1'b0,
    rdata:         RST_BYTE
  };

  // Own address or enabled broadcast address, read direction, acknowledge allowed
  function automatic logic addr_match(input logic [DATA_W-1:0] rx,
                                      input logic [DATA_W-1:0] own,
                                      input logic              ack_en);
    logic hit;
    hit = (rx[7:1] == own[7:1]) || ((rx[7:1] == BCAST_ADDR) && own[0]);
    return hit && rx[0] && ack_en;
  endfunction

  // Status as software sees it
  function automatic logic [DATA_W-1:0] status_view(input logic              flag,
                                                    input logic [DATA_W-1:0] code);
    return flag ? code : CODE_NO_INFO;
  endfunction

  logic       rst_meta_n;
  logic       rst_sync_n;
  twst_regs_t r_reg;
  twst_regs_t r_next;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic in_frame;
  logic wr_ctl;
  logic flag_clr;
  logic flag_set;

  always_comb begin
    r_next = r_reg;

    start_cond = SCL_IN && r_reg.scl_prev && r_reg.sda_prev && !SDA_IN;
    stop_cond  = SCL_IN && r_reg.scl_prev && !r_reg.sda_prev && SDA_IN;
    scl_rise   = SCL_IN && !r_reg.scl_prev;
    scl_fall   = !SCL_IN && r_reg.scl_prev;
    in_frame   = ((r_reg.state == ST_ADDR) && (r_reg.bitcnt != CNT_ZERO)) ||
                 (r_reg.state == ST_ADDR_ACK) ||
                 (r_reg.state == ST_TX_BITS) ||
                 (r_reg.state == ST_TX_ACK);

    wr_ctl   = REG_WR && (REG_ADDR == OFS_CONTROL);
    flag_clr = wr_ctl && REG_WDATA[CTL_STEP_DONE] && r_reg.flag;
    flag_set = 1'b0;

    r_next.scl_prev    = SCL_IN;
    r_next.sda_prev    = SDA_IN;
    r_next.start_issue = 1'b0;

    if (start_cond) begin
      r_next.busy = 1'b1;
    end else if (stop_cond) begin
      r_next.busy = 1'b0;
    end

    if (wr_ctl) begin
      r_next.ack_en    = REG_WDATA[CTL_ACK_EN];
      r_next.begin_req = REG_WDATA[CTL_BEGIN];
      r_next.halt_req  = REG_WDATA[CTL_HALT];
      r_next.enable    = REG_WDATA[CTL_ENABLE];
    end
    if (REG_WR && (REG_ADDR == OFS_DATA) && r_reg.flag) begin
      r_next.data_byte = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == OFS_OWNADDR)) begin
      r_next.own_addr = REG_WDATA;
    end

    if (!r_reg.enable) begin
      r_next.state = ST_IDLE;
    end else if (in_frame && (start_cond || stop_cond)) begin
      r_next.state = ST_ERR_WAIT;
      r_next.code  = CODE_BUS_ERR;
      flag_set     = 1'b1;
    end else begin
      case (r_reg.state)
        ST_IDLE: begin
          if (start_cond) begin
            r_next.state  = ST_ADDR;
            r_next.bitcnt = CNT_ZERO;
          end
        end
        ST_ADDR: begin
          if (start_cond) begin
            r_next.bitcnt = CNT_ZERO;
          end else if (stop_cond) begin
            r_next.state = ST_IDLE;
          end else if (scl_rise && (r_reg.bitcnt != CNT_ADDR_DONE)) begin
            r_next.shifter = {r_reg.shifter[DATA_W-2:0], SDA_IN};
            r_next.bitcnt  = r_reg.bitcnt + CNT_ONE;
          end else if (scl_fall && (r_reg.bitcnt == CNT_ADDR_DONE)) begin
            if (addr_match(r_reg.shifter, r_reg.own_addr, r_reg.ack_en)) begin
              r_next.state = ST_ADDR_ACK;
            end else begin
              r_next.state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            r_next.state = ST_TX_WAIT;
            r_next.code  = ARB_LOST ? CODE_ARB_SLA_R : CODE_SLA_R;
            flag_set     = 1'b1;
          end
        end
        ST_TX_WAIT: begin
          if (flag_clr) begin
            r_next.state     = ST_TX_BITS;
            r_next.shifter   = r_reg.data_byte;
            r_next.bitcnt    = CNT_ZERO;
            r_next.last_byte = !r_next.ack_en;
          end
        end
        ST_TX_BITS: begin
          if (scl_fall) begin
            r_next.shifter = {r_reg.shifter[DATA_W-2:0], 1'b1};
            r_next.bitcnt  = r_reg.bitcnt + CNT_ONE;
            if (r_reg.bitcnt == CNT_TX_LAST) begin
              r_next.state = ST_TX_ACK;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            r_next.ack_seen = !SDA_IN;
          end else if (scl_fall) begin
            flag_set = 1'b1;
            if (!r_reg.ack_seen) begin
              r_next.code  = CODE_DATA_NACK;
              r_next.state = ST_END_WAIT;
            end else if (r_reg.last_byte) begin
              r_next.code  = CODE_LAST_ACK;
              r_next.state = ST_END_WAIT;
            end else begin
              r_next.code  = CODE_DATA_ACK;
              r_next.state = ST_TX_WAIT;
            end
          end
        end
        ST_END_WAIT: begin
          if (flag_clr) begin
            // Recognition afterwards follows ack_en alone
            r_next.state = ST_IDLE;
            if (r_next.begin_req) begin
              r_next.start_pending = 1'b1;
            end
          end
        end
        ST_ERR_WAIT: begin
          if (flag_clr) begin
            r_next.state    = ST_IDLE;
            r_next.halt_req = 1'b0;
          end
        end
        default: begin
          r_next.state = ST_IDLE;
        end
      endcase
    end

    // Set wins over a clear in the same cycle
    r_next.flag = flag_set || (r_reg.flag && !flag_clr);

    if (r_reg.start_pending && !r_reg.busy && (r_reg.state == ST_IDLE)) begin
      r_next.start_pending = 1'b0;
      r_next.start_issue   = 1'b1;
    end

    r_next.scl_drive = r_next.flag &&
                       ((r_next.state == ST_TX_WAIT) || (r_next.state == ST_END_WAIT));
    r_next.sda_drive = (r_next.state == ST_ADDR_ACK) ||
                       ((r_next.state == ST_TX_BITS) && !r_next.shifter[DATA_W-1]);

    r_next.rdata = RST_BYTE;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_CONTROL: begin
          r_next.rdata = RST_BYTE;
          r_next.rdata[CTL_STEP_DONE] = r_reg.flag;
          r_next.rdata[CTL_ACK_EN]    = r_reg.ack_en;
          r_next.rdata[CTL_BEGIN]     = r_reg.begin_req;
          r_next.rdata[CTL_HALT]      = r_reg.halt_req;
          r_next.rdata[CTL_ENABLE]    = r_reg.enable;
        end
        OFS_STATUS: begin
          r_next.rdata = status_view(r_reg.flag, r_reg.code);
        end
        OFS_DATA: begin
          r_next.rdata = r_reg.data_byte;
        end
        OFS_OWNADDR: begin
          r_next.rdata = r_reg.own_addr;
        end
        default: begin
          r_next.rdata = RST_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign REG_RDATA   = r_reg.rdata;
  assign SCL_OUT     = 1'b0;
  assign SCL_OE      = r_reg.scl_drive;
  assign SDA_OUT     = 1'b0;
  assign SDA_OE      = r_reg.sda_drive;
  assign START_ISSUE = r_reg.start_issue;
  assign STEP_DONE   = r_reg.flag;

endmodule

// [logic/twst_pkg.sv]
package twst_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 2;
  localparam int unsigned BITCNT_W   = 4;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_DATA    = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_OWNADDR = 2'h3;

  localparam int unsigned CTL_STEP_DONE = 7;
  localparam int unsigned CTL_ACK_EN    = 6;
  localparam int unsigned CTL_BEGIN     = 5;
  localparam int unsigned CTL_HALT      = 4;
  localparam int unsigned CTL_ENABLE    = 2;

  localparam logic [DATA_W-1:0] CODE_SLA_R     = 8'h00_A8;
  localparam logic [DATA_W-1:0] CODE_ARB_SLA_R = 8'h00_B0;
  localparam logic [DATA_W-1:0] CODE_DATA_ACK  = 8'h00_B8;
  localparam logic [DATA_W-1:0] CODE_DATA_NACK = 8'h00_C0;
  localparam logic [DATA_W-1:0] CODE_LAST_ACK  = 8'h00_C8;
  localparam logic [DATA_W-1:0] CODE_NO_INFO   = 8'h00_F8;
  localparam logic [DATA_W-1:0] CODE_BUS_ERR   = 8'h00_00;

  localparam logic [DATA_W-1:0]   RST_BYTE      = 8'h00_00;
  localparam logic [6:0]          BCAST_ADDR    = 7'h00;
  localparam logic [BITCNT_W-1:0] CNT_ZERO      = 4'h0;
  localparam logic [BITCNT_W-1:0] CNT_ONE       = 4'h1;
  localparam logic [BITCNT_W-1:0] CNT_ADDR_DONE = 4'h8;
  localparam logic [BITCNT_W-1:0] CNT_TX_LAST   = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_TX_WAIT  = 3'b011,
    ST_TX_BITS  = 3'b100,
    ST_TX_ACK   = 3'b101,
    ST_END_WAIT = 3'b110,
    ST_ERR_WAIT = 3'b111
  } twst_state_t;

endpackage

// [dv/twst_slave_tx_sva.sv]
`timescale 1ns/1ns
module twst_slave_tx_sva
  import twst_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic              SCL_IN,
  input wire logic              SCL_OE,
  input wire logic              SDA_IN,
  input wire logic              SDA_OE,
  input wire logic              START_ISSUE,
  input wire logic              STEP_DONE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic clr_wr;
  assign clr_wr = REG_WR && REG_ADDR == OFS_CONTROL && REG_WDATA[CTL_STEP_DONE];
  a_status_idle: assert property (
    REG_RD && REG_ADDR == OFS_STATUS && !STEP_DONE |=> REG_RDATA == CODE_NO_INFO)
    else $error("Status not idle code");
  a_flag_holds: assert property (STEP_DONE && !clr_wr |=> STEP_DONE)
    else $error("Flag dropped");
  a_flag_clears: assert property (STEP_DONE && clr_wr |=> !STEP_DONE)
    else $error("Flag not cleared");
  a_clock_held: assert property (STEP_DONE && SCL_OE && !clr_wr |=> SCL_OE)
    else $error("Clock stretch lost");
  a_clock_freed: assert property (STEP_DONE && SCL_OE && clr_wr |-> ##[1:2] !SCL_OE)
    else $error("Clock not freed");
  a_start_pulse: assert property (START_ISSUE |=> !START_ISSUE)
    else $error("Start request too long");
  a_start_free: assert property (START_ISSUE |-> SCL_IN && SDA_IN)
    else $error("Start request on busy bus");
  a_error_free: assert property (STEP_DONE && !SCL_OE |-> !SDA_OE)
    else $error("Data line held after error");
  c_flag: cover property ($rose(STEP_DONE));
  c_start: cover property (START_ISSUE);
  c_error: cover property (STEP_DONE && !SCL_OE);
endmodule
bind twst_slave_tx twst_slave_tx_sva u_sva (.CLK(CLK), .RESET_N(RESET_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN),
  .SDA_OE(SDA_OE), .START_ISSUE(START_ISSUE), .STEP_DONE(STEP_DONE));

// [dv/twst_bus_master.sv]
`timescale 1ns/1ns
module twst_bus_master (
  input  wire logic CLK,
  input  wire logic SCL_OE,
  input  wire logic SDA_OE,
  output logic      scl,
  output logic      sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Wired-and with pull-ups
  assign scl = !(SCL_OE || scl_low);
  assign sda = !(SDA_OE || sda_low);
  task automatic half();
    repeat (8) @(posedge CLK);
  endtask
  task automatic rise();
    scl_low <= 1'b0;
    for (int i = 0; i < 99 && !scl; i++) @(posedge CLK);
    half();
  endtask
  task automatic start();
    @(posedge CLK);
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    rise();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    half();
    rise();
    r = sda;
    scl_low <= 1'b1;
    half();
  endtask
  task automatic bytex(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bitx(t[i], r[i]);
  endtask
endmodule

// [dv/tb_twst_slave_tx.sv]
`timescale 1ns/1ns
module tb_twst_slave_tx
  import twst_pkg::*;
;
  logic              CLK = 1'b0;
  logic              RESET_N = 1'b0;
  logic [ADDR_W-1:0] REG_ADDR = '0;
  logic [DATA_W-1:0] REG_WDATA = '0;
  logic              REG_WR = 1'b0;
  logic              REG_RD = 1'b0;
  logic              ARB_LOST = 1'b0;
  logic [DATA_W-1:0] REG_RDATA;
  logic              SCL_OE, SDA_OE, START_ISSUE, STEP_DONE, scl, sda, a;
  logic              SCL_OUT, SDA_OUT;
  logic [7:0]        v;
  int                mismatches = 0;
  int                num_checks = 0;
  int                pulses = 0;
  always #4 CLK = !CLK;
  always @(posedge CLK) if (START_ISSUE === 1'b1) pulses++;
  twst_slave_tx u_dut (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .ARB_LOST(ARB_LOST), .START_ISSUE(START_ISSUE),
    .STEP_DONE(STEP_DONE));
  twst_bus_master m (.CLK(CLK), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .scl(scl), .sda(sda));
  function automatic logic [7:0] ctl(input logic [3:0] f);
    logic [7:0] c;
    c = 8'h00;
    c[CTL_STEP_DONE] = f[3];
    c[CTL_ACK_EN] = f[2];
    c[CTL_BEGIN] = f[1];
    c[CTL_HALT] = f[0];
    c[CTL_ENABLE] = 1'b1;
    return c;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, output logic [7:0] d);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic t_reset();
    rd(OFS_STATUS, v);
    check(v, CODE_NO_INFO);
    rd(OFS_CONTROL, v);
    check(v, 8'h00);
    // Data writes are refused while no step is pending
    wr(OFS_DATA, 8'hA5);
    rd(OFS_DATA, v);
    check(v, 8'h00);
    wr(OFS_OWNADDR, 8'h52);
    rd(OFS_OWNADDR, v);
    check(v, 8'h52);
  endtask
  task automatic t_addr(input logic [7:0] code);
    m.start();
    m.bytex(8'h53, v);
    m.bitx(1'b1, a);
    check(8'(a), 8'h00);
    check(8'(STEP_DONE), 8'h01);
    check(8'(SCL_OE), 8'h01);
    rd(OFS_STATUS, v);
    check(v, code);
  endtask
  task automatic t_byte(input logic [7:0] d, input logic ae, input logic mack,
                        input logic [7:0] code);
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, ctl({1'b1, ae, 2'b00}));
    rd(OFS_STATUS, v);
    check(v, CODE_NO_INFO);
    m.bytex(8'hFF, v);
    check(v, d);
    m.bitx(!mack, a);
    rd(OFS_STATUS, v);
    check(v, code);
  endtask
  task automatic t_ignore();
    wr(OFS_CONTROL, ctl(4'h8));
    m.stop();
    m.start();
    m.bytex(8'h53, v);
    m.bitx(1'b1, a);
    check(8'(a), 8'h01);
    m.stop();
    check(8'(STEP_DONE), 8'h00);
  endtask
  task automatic t_begin();
    wr(OFS_CONTROL, ctl(4'hE));
    repeat (20) @(posedge CLK);
    check(8'(pulses), 8'h00);
    m.stop();
    repeat (8) @(posedge CLK);
    check(8'(pulses), 8'h01);
    ARB_LOST <= 1'b1;
  endtask
  task automatic t_error();
    @(posedge CLK);
    ARB_LOST <= 1'b0;
    wr(OFS_DATA, 8'hFF);
    wr(OFS_CONTROL, ctl(4'hC));
    repeat (3) m.bitx(1'b1, a);
    m.stop();
    rd(OFS_STATUS, v);
    check(v, CODE_BUS_ERR);
    check(8'(STEP_DONE), 8'h01);
    check({6'h00, SCL_OE, SDA_OE}, 8'h00);
    check({6'h00, SCL_OUT, SDA_OUT}, 8'h00);
    wr(OFS_CONTROL, ctl(4'hD));
    rd(OFS_CONTROL, v);
    check(v, ctl(4'h4));
    rd(OFS_STATUS, v);
    check(v, CODE_NO_INFO);
  endtask
  // Broadcast address with read is taken once bit 0 of the own address is set
  task automatic t_bcast();
    wr(OFS_OWNADDR, 8'h53);
    m.start();
    m.bytex(8'h01, v);
    m.bitx(1'b1, a);
    check(8'(a), 8'h00);
    check(8'(STEP_DONE), 8'h01);
    rd(OFS_STATUS, v);
    check(v, CODE_SLA_R);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    wr(OFS_CONTROL, ctl(4'h4));
    t_addr(CODE_SLA_R);
    t_byte(8'hA5, 1'b1, 1'b1, CODE_DATA_ACK);
    t_byte(8'h3C, 1'b0, 1'b1, CODE_LAST_ACK);
    t_ignore();
    wr(OFS_CONTROL, ctl(4'h4));
    t_addr(CODE_SLA_R);
    t_byte(8'h5A, 1'b1, 1'b0, CODE_DATA_NACK);
    t_begin();
    t_addr(CODE_ARB_SLA_R);
    t_error();
    t_bcast();
    print_verdict();
  end
endmodule
